/* File: inc/psd_pkg.sv */
// Constants, types and helpers for the priority signal discriminator
// What this block does
// - Class I band: 9.639 Hz +/- 0.119 Hz
// - Class II band: 14.035 Hz +/- 0.255 Hz
// - Call valid only after over 0.5 s in band
// - Superposed Class I trains never make Class II
// - Hold valid call through dropouts, 4.5 to 11 s
// - Hold selectable: 5 s or 10 s
// - Each channel output pulls controller input low
// - Class I output: 6.25 Hz square, 50 percent duty
// - Class II output: held steadily active
// - Class II overrides Class I on output
// - Two independent channels, no interaction
// - Primary plus two auxiliary inputs per channel
// - Centre-off test switch: down Class I, up II
// - Signal lamp shows any in-band reception
// - Call lamp shows steady valid coded signal
// - Optional single lamp: flash signal, steady call
package psd_pkg;
   localparam int CLK_HZ = 50000000;
   localparam int TICK_US = 10;
   localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
   localparam int TICKS_PER_S = 1000000 / TICK_US;
   localparam int TICKS_MHZ_NUM = TICKS_PER_S * 1000;
   localparam int PER_W = 14;
   localparam int RUN_W = 16;
   localparam int HOLD_W = 20;
   localparam int SQ_W = 14;
   localparam int BLINK_W = 15;
   localparam int TICK_W = 16;
   // Decode bands in millihertz
   localparam int C1_MHZ = 9639;
   localparam int C1_TOL_MHZ = 119;
   localparam int C2_MHZ = 14035;
   localparam int C2_TOL_MHZ = 255;
   localparam logic [PER_W-1:0] C1_PER_MIN =
      PER_W'((TICKS_MHZ_NUM + C1_MHZ + C1_TOL_MHZ - 1) / (C1_MHZ + C1_TOL_MHZ));
   localparam logic [PER_W-1:0] C1_PER_MAX = PER_W'(TICKS_MHZ_NUM / (C1_MHZ - C1_TOL_MHZ));
   localparam logic [PER_W-1:0] C2_PER_MIN =
      PER_W'((TICKS_MHZ_NUM + C2_MHZ + C2_TOL_MHZ - 1) / (C2_MHZ + C2_TOL_MHZ));
   localparam logic [PER_W-1:0] C2_PER_MAX = PER_W'(TICKS_MHZ_NUM / (C2_MHZ - C2_TOL_MHZ));
   // A gap longer than any legal period ends a pulse train
   localparam logic [PER_W-1:0] PER_TIMEOUT = PER_W'(C1_PER_MAX + 1);
   localparam int VALID_MS = 500;
   localparam logic [RUN_W-1:0] VALID_TICKS = RUN_W'(VALID_MS * TICKS_PER_S / 1000);
   localparam int HOLD_SHORT_S = 5;
   localparam int HOLD_LONG_S = 10;
   localparam int HOLD_SHORT_TICKS = HOLD_SHORT_S * TICKS_PER_S;
   localparam int HOLD_LONG_TICKS = HOLD_LONG_S * TICKS_PER_S;
   localparam int SQ_CENTI_HZ = 625;
   localparam logic [SQ_W-1:0] SQ_HALF_TICKS = SQ_W'(TICKS_PER_S * 100 / (2 * SQ_CENTI_HZ));
   localparam int BLINK_HZ = 2;
   localparam logic [BLINK_W-1:0] BLINK_HALF_TICKS = BLINK_W'(TICKS_PER_S / (2 * BLINK_HZ));
   // Register map
   localparam logic [31:0] REG_CTRL = 32'h0000_0000;
   localparam logic [31:0] REG_STATUS = 32'h0000_0004;
   localparam int CTRL_HOLD_LONG_A = 0;
   localparam int CTRL_HOLD_LONG_B = 1;
   localparam int CTRL_ONE_LAMP = 2;
   localparam int CTRL_W = 3;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
   localparam int STAT_CH_STRIDE = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [2:0] sy;
      logic lvl;
      logic [PER_W-1:0] per;
      logic [1:0] band;
      logic [1:0][RUN_W-1:0] run;
      logic [1:0] val;
      logic [1:0] sig;
   } psd_dec_type;

   function automatic logic psd_in_band(input logic [PER_W-1:0] p, input logic cls);
      if (cls)
         return (p >= C2_PER_MIN) && (p <= C2_PER_MAX);
      return (p >= C1_PER_MIN) && (p <= C1_PER_MAX);
   endfunction

   function automatic logic [RUN_W-1:0] psd_sat_add(input logic [RUN_W-1:0] a,
                                                    input logic [PER_W-1:0] b);
      logic [RUN_W:0] s;
      s = {1'b0, a} + {{(RUN_W + 1 - PER_W){1'b0}}, b};
      return s[RUN_W] ? {RUN_W{1'b1}} : s[RUN_W-1:0];
   endfunction
endpackage

/* File: core/psd_decoder.sv */
// One detector input: synchroniser, period measurement and class validation
`timescale 1ns/100ps
module psd_decoder (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic det_in,
   output logic [1:0] valid,
   output logic [1:0] sig
);
   psd_pkg::psd_dec_type r;
   psd_pkg::psd_dec_type next_r;
   logic stable;
   logic edge_seen;
   logic [1:0] bnd;
   logic [1:0][psd_pkg::RUN_W-1:0] sum;

   always_comb begin
      next_r = r;
      next_r.sy = {r.sy[1:0], det_in};
      // Level changes only once the second and third stages agree
      stable = (r.sy[2] == r.sy[1]) ? r.sy[2] : r.lvl;
      next_r.lvl = stable;
      edge_seen = stable & ~r.lvl;
      for (int c = 0; c < 2; c++) begin
         bnd[c] = psd_pkg::psd_in_band(r.per, c[0]);
         sum[c] = psd_pkg::psd_sat_add(r.run[c], r.per);
      end
      if (tick && r.per != psd_pkg::PER_TIMEOUT)
         next_r.per = r.per + 1'b1;
      if (edge_seen) begin
         next_r.per = '0;
         next_r.band = bnd;
         next_r.sig = bnd;
         for (int c = 0; c < 2; c++) begin
            // Two back-to-back in-band intervals are needed; a Class I mix always
            // places a pulse inside any 70 ms gap pair, so it cannot pass
            next_r.run[c] = !bnd[c] ? '0 : (r.band[c] ? sum[c] : {2'h0, r.per});
            next_r.val[c] = bnd[c] && r.band[c] && (sum[c] > psd_pkg::VALID_TICKS);
         end
      end else if (r.per == psd_pkg::PER_TIMEOUT) begin
         next_r.band = '0;
         next_r.run = '0;
         next_r.val = '0;
         next_r.sig = '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '{sy: 3'h0, lvl: 1'b0, per: psd_pkg::PER_TIMEOUT, band: 2'h0,
                run: '0, val: 2'h0, sig: 2'h0};
      end else begin
         r <= next_r;
      end
   end

   assign valid = r.val;
   assign sig = r.sig;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_VALID_AFTER_RUN: assert property (r.val[0] |-> r.run[0] > psd_pkg::VALID_TICKS)
      else $error("Class I valid before run time");
   AST_CL1_BAND: assert property ($rose(r.val[0]) |->
      $past(psd_pkg::psd_in_band(r.per, 1'b0)))
      else $error("Class I valid from out-of-band period");
   AST_CL2_CONSEC: assert property (r.val[1] |-> r.band[1] && $past(r.band[1], 2))
      else $error("Class II valid without consecutive in-band intervals");
endmodule

/* File: core/psd_top.sv */
// Two-channel priority signal discriminator with AXI4-Lite control
`timescale 1ns/100ps
module psd_top #(
   parameter int TICK_CYCLES = psd_pkg::TICK_CYCLES,
   parameter int HOLD_SHORT_TICKS = psd_pkg::HOLD_SHORT_TICKS,
   parameter int HOLD_LONG_TICKS = psd_pkg::HOLD_LONG_TICKS
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [1:0] DET_PRI,
   input wire logic [3:0] DET_AUX,
   input wire logic [1:0] TEST_DOWN,
   input wire logic [1:0] TEST_UP,
   output logic [1:0] CH_OUT_N,
   output logic [3:0] SIG_LAMP,
   output logic [3:0] CALL_LAMP,
   input wire logic [31:0] AWADDR,
   input wire logic [2:0] AWPROT,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [31:0] ARADDR,
   input wire logic [2:0] ARPROT,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);
   localparam logic [psd_pkg::HOLD_W-1:0] HOLD_SHORT = psd_pkg::HOLD_W'(HOLD_SHORT_TICKS);
   localparam logic [psd_pkg::HOLD_W-1:0] HOLD_LONG = psd_pkg::HOLD_W'(HOLD_LONG_TICKS);
   localparam logic [psd_pkg::TICK_W-1:0] TICK_LAST = psd_pkg::TICK_W'(TICK_CYCLES - 1);

   typedef struct packed {
      logic [psd_pkg::TICK_W-1:0] tcnt;
      logic tick;
      logic [1:0][2:0] sy_dn;
      logic [1:0][2:0] sy_up;
      logic [1:0] tdn;
      logic [1:0] tup;
      logic [1:0][1:0][psd_pkg::HOLD_W-1:0] hold;
      logic [1:0][1:0] call;
      logic [1:0][psd_pkg::SQ_W-1:0] sq;
      logic [1:0] ph;
      logic [psd_pkg::BLINK_W-1:0] bcnt;
      logic blink;
      logic [1:0] out_n;
      logic [3:0] sig_lamp;
      logic [3:0] call_lamp;
      logic [psd_pkg::CTRL_W-1:0] ctrl;
      logic awrdy;
      logic wrdy;
      logic [31:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arrdy;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } psd_state_type;

   psd_state_type r;
   psd_state_type next_r;
   logic [5:0] det_all;
   logic [5:0][1:0] dval;
   logic [5:0][1:0] dsig;
   logic [1:0][1:0] vld;
   logic [1:0][1:0] sig;
   logic [31:0] status;

   assign det_all = {DET_AUX, DET_PRI};

   // One decoder per input; channel A uses 0,2,3 and channel B uses 1,4,5
   for (genvar i = 0; i < 6; i++) begin : g_dec
      psd_decoder u_dec (
         .clk(CLK),
         .rst(RST),
         .tick(r.tick),
         .det_in(det_all[i]),
         .valid(dval[i]),
         .sig(dsig[i])
      );
   end

   always_comb begin
      next_r = r;
      status = '0;
      // Shared 10 us timebase for all period and hold counts
      next_r.tick = (r.tcnt == TICK_LAST);
      next_r.tcnt = next_r.tick ? '0 : r.tcnt + 1'b1;
      if (r.tick) begin
         if (r.bcnt == psd_pkg::BLINK_HALF_TICKS - 1'b1) begin
            next_r.bcnt = '0;
            next_r.blink = ~r.blink;
         end else begin
            next_r.bcnt = r.bcnt + 1'b1;
         end
      end
      for (int ch = 0; ch < 2; ch++) begin
         next_r.sy_dn[ch] = {r.sy_dn[ch][1:0], TEST_DOWN[ch]};
         next_r.sy_up[ch] = {r.sy_up[ch][1:0], TEST_UP[ch]};
         if (r.sy_dn[ch][2] == r.sy_dn[ch][1])
            next_r.tdn[ch] = r.sy_dn[ch][2];
         if (r.sy_up[ch][2] == r.sy_up[ch][1])
            next_r.tup[ch] = r.sy_up[ch][2];
         for (int c = 0; c < 2; c++) begin
            // Primary and both auxiliaries feed the same class decision
            sig[ch][c] = dsig[ch][c] | dsig[2 + 2 * ch][c] | dsig[3 + 2 * ch][c];
            vld[ch][c] = dval[ch][c] | dval[2 + 2 * ch][c] | dval[3 + 2 * ch][c];
         end
         // Centre-off switch: down tests Class I, up tests Class II
         vld[ch][0] = vld[ch][0] | r.tdn[ch];
         vld[ch][1] = vld[ch][1] | r.tup[ch];
         for (int c = 0; c < 2; c++) begin
            if (vld[ch][c]) begin
               // Each valid period reloads the hold time
               next_r.hold[ch][c] = r.ctrl[ch] ? HOLD_LONG : HOLD_SHORT;
               next_r.call[ch][c] = 1'b1;
            end else if (r.tick && r.hold[ch][c] != '0) begin
               // Dropouts shorter than the hold keep the call
               next_r.hold[ch][c] = r.hold[ch][c] - 1'b1;
               if (r.hold[ch][c] == 1)
                  next_r.call[ch][c] = 1'b0;
            end
         end
         // Square wave starts in its active half whenever a Class I call begins
         if (!next_r.call[ch][0] || next_r.call[ch][1]) begin
            next_r.sq[ch] = '0;
            next_r.ph[ch] = 1'b1;
         end else if (r.tick) begin
            if (r.sq[ch] == psd_pkg::SQ_HALF_TICKS - 1'b1) begin
               next_r.sq[ch] = '0;
               next_r.ph[ch] = ~r.ph[ch];
            end else begin
               next_r.sq[ch] = r.sq[ch] + 1'b1;
            end
         end
         // Low output means the controller input is grounded
         // Class II is steady and wins over Class I
         next_r.out_n[ch] = ~(next_r.call[ch][1] | (next_r.call[ch][0] & next_r.ph[ch]));
         for (int c = 0; c < 2; c++) begin
            if (r.ctrl[psd_pkg::CTRL_ONE_LAMP]) begin
               // Single lamp: steady for call, flashing for signal only
               next_r.sig_lamp[2 * ch + c] = 1'b0;
               next_r.call_lamp[2 * ch + c] = vld[ch][c] | (sig[ch][c] & r.blink);
            end else begin
               next_r.sig_lamp[2 * ch + c] = sig[ch][c];
               next_r.call_lamp[2 * ch + c] = vld[ch][c];
            end
         end
         status[ch * psd_pkg::STAT_CH_STRIDE +: 5] =
            {~r.out_n[ch], r.call[ch][1], r.call[ch][0], sig[ch][1], sig[ch][0]};
      end
      // Write channel: address and data taken in either order
      if (AWVALID && r.awrdy) begin
         next_r.awrdy = 1'b0;
         next_r.awaddr = AWADDR;
      end
      if (WVALID && r.wrdy) begin
         next_r.wrdy = 1'b0;
         next_r.wdata = WDATA;
         next_r.wstrb = WSTRB;
      end
      if (!r.awrdy && !r.wrdy && !r.bvalid) begin
         next_r.bvalid = 1'b1;
         next_r.bresp = psd_pkg::RESP_OKAY;
         if (r.awaddr[31:2] == psd_pkg::REG_CTRL[31:2]) begin
            if (r.wstrb[0])
               next_r.ctrl = r.wdata[psd_pkg::CTRL_W-1:0];
         end else if (r.awaddr[31:2] != psd_pkg::REG_STATUS[31:2]) begin
            next_r.bresp = psd_pkg::RESP_SLVERR;
         end
      end
      if (r.bvalid && BREADY) begin
         next_r.bvalid = 1'b0;
         next_r.awrdy = 1'b1;
         next_r.wrdy = 1'b1;
      end
      // Read channel answers one cycle after the address is taken
      if (ARVALID && r.arrdy) begin
         next_r.arrdy = 1'b0;
         next_r.rvalid = 1'b1;
         next_r.rresp = psd_pkg::RESP_OKAY;
         if (ARADDR[31:2] == psd_pkg::REG_CTRL[31:2]) begin
            next_r.rdata = {{(32 - psd_pkg::CTRL_W){1'b0}}, r.ctrl};
         end else if (ARADDR[31:2] == psd_pkg::REG_STATUS[31:2]) begin
            next_r.rdata = status;
         end else begin
            next_r.rdata = '0;
            next_r.rresp = psd_pkg::RESP_SLVERR;
         end
      end
      if (r.rvalid && RREADY) begin
         next_r.rvalid = 1'b0;
         next_r.arrdy = 1'b1;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         r <= '0;
         r.ctrl <= psd_pkg::CTRL_RESET;
         r.out_n <= 2'h3;
         r.ph <= 2'h3;
         r.awrdy <= 1'b1;
         r.wrdy <= 1'b1;
         r.arrdy <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign CH_OUT_N = r.out_n;
   assign SIG_LAMP = r.sig_lamp;
   assign CALL_LAMP = r.call_lamp;
   assign AWREADY = r.awrdy;
   assign WREADY = r.wrdy;
   assign BVALID = r.bvalid;
   assign BRESP = r.bresp;
   assign ARREADY = r.arrdy;
   assign RVALID = r.rvalid;
   assign RDATA = r.rdata;
   assign RRESP = r.rresp;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   AST_CL2_STEADY: assert property (r.call[0][1] && $past(r.call[0][1]) |-> !CH_OUT_N[0]
         && $stable(CH_OUT_N[0]))
      else $error("Class II call but output not steadily active");
   AST_CL2_WINS: assert property (r.call[1] == 2'h3 |-> !CH_OUT_N[1])
      else $error("Class II did not take precedence");
   AST_IDLE_OFF: assert property (r.call[0] == 2'h0 |-> CH_OUT_N[0])
      else $error("Output active without a call");
   AST_SQ_HALF: assert property ($changed(CH_OUT_N[0]) && r.call[0] == 2'h1
         && $past(r.call[0]) == 2'h1 |-> $past(r.sq[0]) == psd_pkg::SQ_HALF_TICKS - 1'b1
         && $past(r.tick))
      else $error("Class I square wave toggled off its half period");
   AST_HOLD_LOAD: assert property (vld[0][1] |=> r.call[0][1]
         && r.hold[0][1] == ($past(r.ctrl[0]) ? HOLD_LONG : HOLD_SHORT))
      else $error("Hold time not reloaded on valid signal");
   AST_CALL_DROP: assert property ($fell(r.call[0][0]) |-> $past(r.hold[0][0]) == 1
         && $past(r.tick) && !$past(vld[0][0]))
      else $error("Class I call dropped before hold expired");
   AST_TEST_UP: assert property (r.tup[1] |=> r.call[1][1] ##1 !CH_OUT_N[1])
      else $error("Up test switch did not force Class II");
   AST_B_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("Write response dropped before acceptance");
   AST_R_NEXT: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("Read answer not given one cycle after address");

   COV_CL1_CALL: cover property (r.call[0] == 2'h1 ##1 $changed(CH_OUT_N[0]));
   COV_CL2_CALL: cover property ($rose(r.call[1][1]));
   COV_BOTH: cover property (r.call[0] == 2'h3);
   COV_DROP: cover property ($fell(r.call[0][0]));
endmodule

/* File: verification/psd_ctl_model.sv */
// Controller-side model: times the active-low channel outputs
`timescale 1ns/100ps
module psd_ctl_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] in_n,
   output logic [1:0][31:0] low_w,
   output logic [1:0][31:0] high_w,
   output logic [1:0][31:0] rises
);
   logic [1:0] last;
   logic [1:0][31:0] run;
   // A grounded input reads as a call; widths are whole clock cycles
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last <= 2'h3;
         run <= '0;
         low_w <= '0;
         high_w <= '0;
         rises <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            run[i] <= run[i] + 32'h1;
            if (in_n[i] !== last[i]) begin
               run[i] <= 32'h1;
               if (last[i])
                  high_w[i] <= run[i];
               else
                  low_w[i] <= run[i];
               if (in_n[i])
                  rises[i] <= rises[i] + 32'h1;
            end
            last[i] <= in_n[i];
         end
      end
   end
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the two-channel priority discriminator
`timescale 1ns/100ps
module tb;
   logic CLK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
   logic ARVALID, ARREADY, RVALID, RREADY;
   logic [1:0] DET_PRI, TEST_DOWN, TEST_UP, CH_OUT_N, BRESP, RRESP, resp;
   logic [3:0] DET_AUX, SIG_LAMP, CALL_LAMP, WSTRB;
   logic [31:0] AWADDR, WDATA, ARADDR, RDATA, rd, r0, r1;
   logic [1:0][31:0] low_w, high_w, rises;
   logic [5:0][31:0] per, cnt, off;
   logic [5:0] det;
   int mismatches, check_count;
   assign {DET_AUX, DET_PRI} = det;

   // One tick per clock keeps a half-second validation inside the run budget
   psd_top #(.TICK_CYCLES(1), .HOLD_SHORT_TICKS(50), .HOLD_LONG_TICKS(100)) i_psd_top (
      .CLK(CLK), .RST(RST), .DET_PRI(DET_PRI), .DET_AUX(DET_AUX), .TEST_DOWN(TEST_DOWN),
      .TEST_UP(TEST_UP), .CH_OUT_N(CH_OUT_N), .SIG_LAMP(SIG_LAMP), .CALL_LAMP(CALL_LAMP),
      .AWADDR(AWADDR), .AWPROT(3'h0), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
      .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
      .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(3'h0), .ARVALID(ARVALID), .ARREADY(ARREADY),
      .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
   psd_ctl_model i_psd_ctl_model (.clk(CLK), .rst(RST), .in_n(CH_OUT_N), .low_w(low_w),
      .high_w(high_w), .rises(rises));

   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end

   // Emitter trains, period in cycles; a zero period stops the train
   // A nonzero offset overlays a second train of the same period on that input
   always @(posedge CLK) begin
      for (int i = 0; i < 6; i++) begin
         cnt[i] <= (per[i] == 0 || cnt[i] + 1 >= per[i]) ? 32'h0 : cnt[i] + 32'h1;
         det[i] <= (per[i] != 0) && (cnt[i] < 100
            || (off[i] != 0 && cnt[i] >= off[i] && cnt[i] < off[i] + 100));
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge CLK);
      AWADDR <= a;
      WDATA <= d;
      WSTRB <= s;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do begin
         @(posedge CLK);
         if (AWVALID && AWREADY) begin
            aw = 1'b1;
            AWVALID <= 1'b0;
         end
         if (WVALID && WREADY) begin
            w = 1'b1;
            WVALID <= 1'b0;
         end
      end while (!(aw && w && BVALID === 1'b1));
      resp = BRESP;
      BREADY <= 1'b0;
   endtask

   task automatic axi_rd(input logic [31:0] a);
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do begin
         @(posedge CLK);
         if (ARVALID && ARREADY)
            ARVALID <= 1'b0;
      end while (RVALID !== 1'b1);
      rd = RDATA;
      resp = RRESP;
      RREADY <= 1'b0;
   endtask

   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Whole run is about 94.4k cycles; cut off at 97.5k
   initial begin
      #1950000;
      mismatches++;
      end_sim;
   end

   initial begin
      RST = 1'b1;
      {TEST_DOWN, TEST_UP, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
      {AWADDR, WDATA, ARADDR, WSTRB} = '0;
      per = '0;
      off = '0;
      mismatches = 0;
      check_count = 0;
      repeat (12) @(posedge CLK);
      RST <= 1'b0;
      check(32'({SIG_LAMP, CALL_LAMP, CH_OUT_N}), 32'h3);
      axi_rd(psd_pkg::REG_CTRL);
      check(rd, 32'h0);
      axi_wr(psd_pkg::REG_CTRL, 32'h7, 4'h0);
      axi_rd(psd_pkg::REG_CTRL);
      check(rd, 32'h0);
      axi_wr(psd_pkg::REG_CTRL, 32'h1, 4'hF);
      axi_rd(psd_pkg::REG_CTRL);
      check(rd, 32'h1);
      axi_wr(psd_pkg::REG_STATUS, 32'hFF, 4'hF);
      check(32'(resp), 32'(psd_pkg::RESP_OKAY));
      axi_rd(psd_pkg::REG_STATUS);
      check(rd, 32'h0);
      axi_wr(32'h8, 32'h1, 4'hF);
      check(32'(resp), 32'(psd_pkg::RESP_SLVERR));
      axi_rd(32'h10);
      check({rd[29:0], resp}, 32'(psd_pkg::RESP_SLVERR));
      $display("register test done");
      TEST_UP <= 2'h3;
      repeat (50) @(posedge CLK);
      check(32'({CALL_LAMP, CH_OUT_N}), 32'h28);
      TEST_UP <= 2'h0;
      repeat (35) @(posedge CLK);
      check(32'({CALL_LAMP, CH_OUT_N}), 32'h0);
      repeat (40) @(posedge CLK);
      check(32'(CH_OUT_N), 32'h2);
      repeat (55) @(posedge CLK);
      check(32'(CH_OUT_N), 32'h3);
      r0 = rises[0];
      r1 = rises[1];
      TEST_DOWN <= 2'h3;
      TEST_UP <= 2'h1;
      repeat (20) @(posedge CLK);
      check(32'({CALL_LAMP, CH_OUT_N}), 32'h1C);
      repeat (9000) @(posedge CLK);
      check(rises[0] - r0, 32'h0);
      check(rises[1] - r1, 32'h1);
      check(32'(low_w[1] >= 7992 && low_w[1] <= 8008), 32'h1);
      TEST_DOWN <= 2'h0;
      TEST_UP <= 2'h0;
      repeat (300) @(posedge CLK);
      check(32'(CH_OUT_N), 32'h3);
      $display("test switch test done");
      // Class II on channel A second auxiliary, Class I on channel B primary
      // Two Class I trains superposed on channel A first auxiliary leave 7100-cycle gaps
      per[3] <= 32'd7100;
      per[1] <= 32'd10374;
      per[2] <= 32'd10374;
      off[2] <= 32'd3274;
      repeat (51820) @(posedge CLK);
      check(32'({SIG_LAMP, CALL_LAMP}), 32'h60);
      repeat (70) @(posedge CLK);
      check(32'({CALL_LAMP, CH_OUT_N}), 32'h11);
      repeat (4930) @(posedge CLK);
      check(32'({CALL_LAMP, CH_OUT_N}), 32'h18);
      r0 = rises[0];
      axi_rd(psd_pkg::REG_STATUS);
      check(rd & 32'h1F1F, 32'h151A);
      axi_wr(psd_pkg::REG_CTRL, 32'h5, 4'hF);
      repeat (3) @(posedge CLK);
      check(32'({SIG_LAMP, CALL_LAMP}), 32'h06);
      axi_wr(psd_pkg::REG_CTRL, 32'h1, 4'hF);
      repeat (17000) @(posedge CLK);
      check(32'(high_w[1] >= 7992 && high_w[1] <= 8008), 32'h1);
      check(32'(low_w[1] >= 7992 && low_w[1] <= 8008), 32'h1);
      check(rises[0] - r0, 32'h0);
      check(32'(i_psd_top.g_dec[2].u_dec.valid), 32'h0);
      per <= '0;
      repeat (3000) @(posedge CLK);
      check(32'(CH_OUT_N[0]), 32'h0);
      repeat (8000) @(posedge CLK);
      check(32'({CALL_LAMP, CH_OUT_N}), 32'h3);
      $display("detector test done");
      end_sim;
   end
endmodule
